// >>> bench/hsf_adc_model.sv
// Behavioural converter answering each start after a set latency
`timescale 1ns/1ps
module hsf_adc_model (
   input  wire        i_sys_clk,
   input  wire        i_start,
   input  wire [1:0]  i_channel,
   input  wire [2:0]  i_lat,
   input  wire [23:0] i_values,
   output logic       o_done = 1'b0,
   output logic [7:0] o_data = 8'h00
);
   int         wait_q = 0;
   logic [1:0] ch_q = 2'd0;
   always @(posedge i_sys_clk) begin
      o_done <= 1'b0;
      o_data <= ~o_data;
      if (i_start) begin
         wait_q <= i_lat;
         ch_q <= i_channel;
      end else if (wait_q == 1) begin
         o_done <= 1'b1;
         o_data <= i_values[ch_q*8 +: 8];
         wait_q <= 0;
      end else if (wait_q > 1) begin
         wait_q <= wait_q - 1;
      end
   end
endmodule // hsf_adc_model

// >>> bench/hsf_fault_ctl_properties.sv
// Checker for the fault, alert, gate and converter pins
`timescale 1ns/1ps
module hsf_fault_ctl_chk #(
   parameter [31:0] QUAL_CYC = 2000000
) (
   input wire       i_sys_clk,
   input wire       i_sys_rst,
   input wire       i_overvolt_sense,
   input wire       i_undervolt_sense,
   input wire       i_output_feedback,
   input wire       i_board_present_n,
   input wire       i_oc_trip,
   input wire       i_ara_won,
   input wire       i_dev_addressed,
   input wire       i_adc_done,
   input wire       o_gate_drive,
   input wire       o_pgood_pull_low,
   input wire       o_alert_pull_low,
   input wire       o_ara_respond,
   input wire       o_adc_start,
   input wire [1:0] o_adc_channel
);
   int ov_hi_q = 0, uv_hi_q = 0, ov_lo_q = 0, uv_lo_q = 0, bn_lo_q = 0, fb_hi_q = 0;
   // Run lengths of both sense input levels, board-present low and feedback high
   always @(posedge i_sys_clk) begin
      ov_hi_q <= (i_sys_rst || !i_overvolt_sense) ? 0 : ov_hi_q + 1;
      uv_hi_q <= (i_sys_rst || !i_undervolt_sense) ? 0 : uv_hi_q + 1;
      ov_lo_q <= (i_sys_rst || i_overvolt_sense) ? 0 : ov_lo_q + 1;
      uv_lo_q <= (i_sys_rst || i_undervolt_sense) ? 0 : uv_lo_q + 1;
      bn_lo_q <= (i_sys_rst || i_board_present_n) ? 0 : bn_lo_q + 1;
      fb_hi_q <= (i_sys_rst || !i_output_feedback) ? 0 : fb_hi_q + 1;
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   sequence removed_s;
      $rose(i_board_present_n) ##1 i_board_present_n [*5];
   endsequence
   sequence released_s;
      (i_ara_won || i_dev_addressed) ##2 1'b1;
   endsequence
   ov_gate_a:
      assert property (ov_hi_q >= 48 |-> !o_gate_drive) else $error("gate on in overvoltage");
   uv_gate_a:
      assert property (uv_hi_q >= 48 |-> !o_gate_drive) else $error("gate on in undervoltage");
   removal_gate_a:
      assert property (removed_s |-> !o_gate_drive) else $error("gate on after removal");
   oc_gate_a:
      assert property ($rose(i_oc_trip) |-> ##5 !o_gate_drive) else $error("gate on after overcurrent");
   gate_qual_a:
      assert property ($rose(o_gate_drive) |-> bn_lo_q >= QUAL_CYC && ov_lo_q >= QUAL_CYC
                       && uv_lo_q >= QUAL_CYC) else $error("gate on before qualification");
   reset_quiet_a:
      assert property ($fell(i_sys_rst) |-> !o_alert_pull_low [*8]) else $error("alert after reset");
   alert_release_a:
      assert property (released_s |-> !o_alert_pull_low) else $error("alert not released");
   ara_alert_a:
      assert property ($rose(o_ara_respond) |-> ##[0:1] o_alert_pull_low) else $error("answer without alert");
   pgood_free_a:
      assert property (fb_hi_q >= 8 |-> !o_pgood_pull_low) else $error("pgood held low");
   adc_pulse_a:
      assert property (o_adc_start |=> !o_adc_start) else $error("start pulse too long");
   adc_next_a:
      assert property (i_adc_done && o_adc_channel == 2'd0 |-> ##[1:2] (o_adc_start && o_adc_channel == 2'd1))
         else $error("next channel not started");
endmodule // hsf_fault_ctl_chk

bind hsf_fault_ctl hsf_fault_ctl_chk #(.QUAL_CYC(QUAL_CYC)) chk_u (
   .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_overvolt_sense(i_overvolt_sense),
   .i_undervolt_sense(i_undervolt_sense), .i_output_feedback(i_output_feedback),
   .i_board_present_n(i_board_present_n), .i_oc_trip(i_oc_trip), .i_ara_won(i_ara_won),
   .i_dev_addressed(i_dev_addressed), .i_adc_done(i_adc_done), .o_gate_drive(o_gate_drive),
   .o_pgood_pull_low(o_pgood_pull_low), .o_alert_pull_low(o_alert_pull_low),
   .o_ara_respond(o_ara_respond), .o_adc_start(o_adc_start), .o_adc_channel(o_adc_channel));

// >>> bench/testbench.sv
// Self-checking bench for the fault, alert and gate controller
`timescale 1ns/1ps
module testbench;
   localparam int QUAL = 200;
   localparam int COOL = 300;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, rd, tmp;
   logic        fb = 1, bn = 0, onr = 1, oc = 0, won = 0, dadr = 0, gs = 1, uvr = 0, lko = 0;
   logic [1:0]  sense = 0;
   logic [2:0]  lat = 3'd2;
   logic [23:0] vals = 0;
   wire  [31:0] prdata;
   wire         pready, pslverr, gate, pg_low, al_low, ara, start, done;
   wire  [1:0]  ch;
   wire  [7:0]  adat;
   int          n_fail = 0, checks_done = 0, seed = 32'h64b900cc;

   initial forever #25 clk = ~clk;

   hsf_fault_ctl #(.QUAL_CYC(QUAL), .COOL_CYC(COOL), .ADC_PER_CYC(200)) dut_u (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_overvolt_sense(sense[0]), .i_undervolt_sense(sense[1]), .i_output_feedback(fb),
      .i_board_present_n(bn), .i_on_request(onr), .i_gs_adequate(gs), .i_uv_reset(uvr),
      .i_supply_lockout(lko), .i_oc_trip(oc), .o_gate_drive(gate), .o_pgood_pull_low(pg_low),
      .o_alert_pull_low(al_low), .o_ara_respond(ara), .i_ara_won(won), .i_dev_addressed(dadr),
      .o_adc_start(start), .o_adc_channel(ch), .i_adc_done(done), .i_adc_data(adat));
   hsf_adc_model adc_u (.i_sys_clk(clk), .i_start(start), .i_channel(ch), .i_lat(lat),
      .i_values(vals), .o_done(done), .o_data(adat));

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(0, a, 0);
      chk(what, e, rd & m);
   endtask
   task automatic wait_gate(input logic e, input int lim);
      for (int i = 0; i < lim && gate !== e; i++) @(posedge clk);
      chk("gate", e, gate);
   endtask
   task automatic ack(input logic by_ara);
      if (by_ara) won <= 1;
      else dadr <= 1;
      cyc(1);
      won <= 0;
      dadr <= 0;
      cyc(3);
   endtask
   task automatic conv();
      for (int i = 0; i < 400 && !(start === 1'b1 && ch === 2'd0); i++) @(posedge clk);
      cyc(40);
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      cyc(2);
      rst <= 0;
      rdchk("ctrl", 8'h00, 32'hff, 32'h43);
      rdchk("mask", 8'h04, 32'hff, 0);
      chk("alert", 0, al_low);
      apb(0, 8'h1c, 0);
      chk("unmapped", 1, err);
      wait_gate(1, QUAL + 50);
      rdchk("on_ctl", 8'h00, 32'h08, 32'h08);
      // Power-up with a board in counts as an insertion
      rdchk("boot_chg", 8'h0c, 32'h10, 32'h10);
      apb(1, 8'h0c, 0);
      apb(1, 8'h04, 32'h3f);
      tmp = $random(seed);
      sense[0] <= 1;
      cyc(5 + tmp[4:0]);
      sense[0] <= 0;
      cyc(5);
      rdchk("glitch", 8'h0c, 32'h3f, 0);
      for (int k = 0; k < 2; k++) begin
         sense[k] <= 1;
         cyc(60);
         chk("gate_off", 0, gate);
         rdchk("present", 8'h08, 32'h03, 1 << k);
         rdchk("fault", 8'h0c, 32'h3f, 1 << k);
         chk("alert", 1, al_low);
         chk("ara", 1, ara);
         ack(k == 0);
         chk("released", 0, al_low);
         apb(1, 8'h0c, 0);
         rdchk("kept", 8'h0c, 32'h3f, 1 << k);
         sense[k] <= 0;
         wait_gate(1, QUAL + 60);
         rdchk("kept_retry", 8'h0c, 32'h3f, 1 << k);
         chk("no_realert", 0, al_low);
         apb(1, 8'h0c, 0);
         rdchk("cleared", 8'h0c, 32'h3f, 0);
      end
      apb(1, 8'h00, 32'h48);
      apb(1, 8'h0c, 32'h01);
      cyc(20);
      chk("latched", 0, gate);
      apb(1, 8'h0c, 0);
      wait_gate(1, 20);
      ack(0);
      apb(1, 8'h00, 32'h4b);
      apb(1, 8'h0c, 32'h60);
      cyc(2);
      chk("forced", 1, al_low);
      chk("no_ara", 0, ara);
      apb(1, 8'h0c, 0);
      ack(0);
      chk("unforced", 0, al_low);
      gs <= 0;
      fb <= 0;
      cyc(60);
      rdchk("pb_gated", 8'h08, 32'h08, 0);
      gs <= 1;
      cyc(60);
      chk("pgood_low", 1, pg_low);
      rdchk("pbad", 8'h08, 32'h08, 32'h08);
      fb <= 1;
      cyc(10);
      chk("pgood_rel", 0, pg_low);
      rdchk("pbad_gone", 8'h08, 32'h08, 0);
      apb(1, 8'h0c, 0);
      ack(1);
      for (int j = 0; j < 2; j++) begin
         apb(1, 8'h00, j ? 32'h4f : 32'h4b);
         oc <= 1;
         cyc(6);
         oc <= 0;
         chk("oc_off", 0, gate);
         rdchk("oc_flt", 8'h0c, 32'h04, 32'h04);
         cyc(COOL + 50);
         chk("oc_retry", j, gate);
         apb(1, 8'h0c, 0);
         wait_gate(1, 20);
         ack(1);
      end
      apb(1, 8'h0c, 32'h20);
      bn <= 1;
      cyc(6);
      chk("removed", 0, gate);
      rdchk("brd_out", 8'h08, 32'h10, 0);
      rdchk("chg", 8'h0c, 32'h10, 32'h10);
      bn <= 0;
      cyc(6);
      rdchk("insert", 8'h0c, 32'h3f, 32'h10);
      rdchk("brd_in", 8'h08, 32'h10, 32'h10);
      wait_gate(1, QUAL + 20);
      apb(1, 8'h0c, 32'h22);
      onr <= 0;
      cyc(6);
      rdchk("off_clr", 8'h0c, 32'h3f, 0);
      onr <= 1;
      wait_gate(1, 20);
      ack(0);
      for (int j = 0; j < 2; j++) begin
         apb(1, 8'h0c, 32'h28);
         uvr <= (j == 0);
         lko <= (j == 1);
         cyc(50);
         uvr <= 0;
         lko <= 0;
         rdchk("aux_clr", 8'h0c, 32'h3f, 0);
      end
      for (int j = 0; j < 2; j++) begin
         tmp = $random(seed);
         vals <= tmp[23:0];
         lat <= j ? 3'd7 : 3'd2;
         conv();
         rdchk("sense", 8'h10, 32'hff, {24'h0, vals[7:0]});
         rdchk("source", 8'h14, 32'hff, {24'h0, vals[15:8]});
         rdchk("aux", 8'h18, 32'hff, {24'h0, vals[23:16]});
         rdchk("no_short", 8'h0c, 32'h20, 0);
      end
      onr <= 0;
      vals <= 24'h00000b;
      conv();
      conv();
      rdchk("short", 8'h0c, 32'h20, 32'h20);
      apb(1, 8'h00, 32'h63);
      apb(1, 8'h10, 32'h5a);
      cyc(250);
      rdchk("halt_wr", 8'h10, 32'hff, 32'h5a);
      final_report();
   end

   initial begin
      cyc(30000);
      n_fail++;
      final_report();
   end
endmodule // testbench

// >>> design/hsf_defines.vh
// Constants for the fault, alert and gate-control block
// Operation
// - Overvoltage over 2 us: gate off, flags set
// - Overvoltage gone 100 ms: gate may restart
// - Undervoltage over 2 us: gate off, flags set
// - Undervoltage gone 100 ms: gate restarts
// - Any board-present edge sets board change fault
// - Board removal: gate off, clear board present
// - Insertion clears faults, sets board present
// - Board present 100 ms: copy on request
// - Sense code at limit, gate off: short fault
// - Feedback low while on: power bad, pgood pin
// - Enabled fault pulls alert pin low
// - Alert response or addressing releases alert
// - Released alert rearms only on new fault
// - Force-low bit drives alert, blocks response
// - Switch-off, uv reset, lockout clear faults
// - Faults still present cannot be cleared
// - No retry: fault bit holds switch off
// - Retry: present bits, 100 ms wait or cool-down hold switch off
// - Overcurrent sets fault, retries after cool-down
// - Converter cycles three channels ten times/second
// - Halt test stops converter, results writable
// - Written OV, UV or OC one latches gate off with no retry
`ifndef HSF_DEFINES_VH
`define HSF_DEFINES_VH

`define HSF_CLK_PERIOD_NS 50
`define HSF_FILT_NS       2000
`define HSF_FILT_CYC      ((`HSF_FILT_NS + `HSF_CLK_PERIOD_NS - 1) / `HSF_CLK_PERIOD_NS)
`define HSF_QUAL_MS       100
`define HSF_QUAL_CYC      (`HSF_QUAL_MS * 1000 * (1000 / `HSF_CLK_PERIOD_NS))
`define HSF_COOL_MS       5000
`define HSF_COOL_CYC      (`HSF_COOL_MS * 1000 * (1000 / `HSF_CLK_PERIOD_NS))
`define HSF_ADC_MS        100
`define HSF_ADC_CYC       (`HSF_ADC_MS * 1000 * (1000 / `HSF_CLK_PERIOD_NS))

`define HSF_FILT_W        6
`define HSF_QUAL_W        21
`define HSF_COOL_W        27

`define HSF_ADDR_CTRL     8'h00
`define HSF_ADDR_ALERT    8'h04
`define HSF_ADDR_STATUS   8'h08
`define HSF_ADDR_FAULT    8'h0c
`define HSF_ADDR_SENSE    8'h10
`define HSF_ADDR_SOURCE   8'h14
`define HSF_ADDR_AUX      8'h18

`define HSF_CTRL_RST      8'h43
`define HSF_CTRL_OV_AR    0
`define HSF_CTRL_UV_AR    1
`define HSF_CTRL_OC_AR    2
`define HSF_CTRL_ON       3
`define HSF_CTRL_HALT     5
`define HSF_CTRL_PG_MODE  6

`define HSF_FLT_OV        0
`define HSF_FLT_UV        1
`define HSF_FLT_OC        2
`define HSF_FLT_PB        3
`define HSF_FLT_BRD       4
`define HSF_FLT_SHORT     5
`define HSF_FLT_FORCE     6

`define HSF_ST_OV         0
`define HSF_ST_UV         1
`define HSF_ST_PB         3
`define HSF_ST_BRD        4

`define HSF_SHORT_CODE    8'h0b

`endif

// >>> design/hsf_fault_ctl.v
// Fault detection, logging, gate control, alert and converter sequencing
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "hsf_defines.vh"
module hsf_fault_ctl #(
   parameter [31:0] QUAL_CYC    = `HSF_QUAL_CYC,
   parameter [31:0] COOL_CYC    = `HSF_COOL_CYC,
   parameter [31:0] ADC_PER_CYC = `HSF_ADC_CYC
) (
   input  wire        i_sys_clk,
   input  wire        i_sys_rst,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [7:0]  i_paddr,
   input  wire [31:0] i_pwdata,
   output wire [31:0] o_prdata,
   output wire        o_pready,
   output wire        o_pslverr,
   input  wire        i_overvolt_sense,
   input  wire        i_undervolt_sense,
   input  wire        i_output_feedback,
   input  wire        i_board_present_n,
   input  wire        i_on_request,
   input  wire        i_gs_adequate,
   input  wire        i_uv_reset,
   input  wire        i_supply_lockout,
   input  wire        i_oc_trip,
   output wire        o_gate_drive,
   output wire        o_pgood_pull_low,
   output wire        o_alert_pull_low,
   output wire        o_ara_respond,
   input  wire        i_ara_won,
   input  wire        i_dev_addressed,
   output wire        o_adc_start,
   output wire [1:0]  o_adc_channel,
   input  wire        i_adc_done,
   input  wire [7:0]  i_adc_data
);
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_WAIT = 2'b01;
   localparam [31:0] FILT_LIM = `HSF_FILT_CYC;

   // Synchronised pins
   wire [8:0] pin_s;
   wire       ov_s;
   wire       uv_s;
   wire       fb_s;
   wire       brd_n_s;
   wire       on_s;
   wire       gs_s;
   wire       uvrst_s;
   wire       lock_s;
   wire       oc_s;

   hsf_sync #(.WIDTH(9)) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .i_async   ({i_oc_trip, i_supply_lockout, i_uv_reset, i_gs_adequate, i_on_request,
                   i_board_present_n, i_output_feedback, i_undervolt_sense, i_overvolt_sense}),
      .o_sync    (pin_s)
   );

   assign ov_s    = pin_s[0];
   assign uv_s    = pin_s[1];
   assign fb_s    = pin_s[2];
   assign brd_n_s = pin_s[3];
   assign on_s    = pin_s[4];
   assign gs_s    = pin_s[5];
   assign uvrst_s = pin_s[6];
   assign lock_s  = pin_s[7];
   assign oc_s    = pin_s[8];

   // Registers
   reg  [7:0]  ctrl_q;
   reg  [5:0]  mask_q;
   reg  [5:0]  fault_q;
   reg  [5:0]  fault_d;
   reg         force_q;
   reg         ov_pres_q;
   reg         uv_pres_q;
   reg         pb_pres_q;
   reg         brd_pres_q;
   reg         brd_prev_q;
   reg         brd_qual_q;
   reg         on_prev_q;
   reg         ctl_prev_q;
   reg         gate_q;
   reg         pgood_low_q;
   reg         alert_pend_q;
   reg         alert_out_q;
   reg  [5:0]  masked_prev_q;
   reg  [`HSF_COOL_W-1:0] cool_q;
   reg  [`HSF_QUAL_W-1:0] per_q;
   reg  [1:0]  state_q;
   reg  [1:0]  ch_q;
   reg         start_q;
   reg  [7:0]  res_q [0:2];
   reg  [31:0] prdata_q;
   reg  [31:0] rd_val;
   reg         mapped;

   // Filters and qualifiers
   wire [3:0] flt_cond;
   wire [3:0] flt_met;
   wire [2:0] qual_cond;
   wire [2:0] qual_met;
   wire       pb_cond;

   assign pb_cond   = gate_q & gs_s & ~fb_s;
   assign flt_cond  = {uvrst_s, pb_cond, uv_s, ov_s};
   assign qual_cond = {~brd_n_s, ~uv_s, ~ov_s};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_filt
         hsf_qual #(.CNT_W(`HSF_FILT_W), .LIMIT(FILT_LIM[`HSF_FILT_W-1:0])) u_filt (
            .i_sys_clk (i_sys_clk),
            .i_sys_rst (i_sys_rst),
            .i_cond    (flt_cond[gi]),
            .o_met     (flt_met[gi])
         );
      end
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_qual
         hsf_qual #(.CNT_W(`HSF_QUAL_W), .LIMIT(QUAL_CYC[`HSF_QUAL_W-1:0])) u_qual (
            .i_sys_clk (i_sys_clk),
            .i_sys_rst (i_sys_rst),
            .i_cond    (qual_cond[gi]),
            .o_met     (qual_met[gi])
         );
      end
   endgenerate

   // Bus decode
   wire setup_ph = i_psel & ~i_penable;
   wire acc_ph   = i_psel & i_penable;
   wire wr_en    = acc_ph & i_pwrite & mapped;
   wire wr_ctrl  = wr_en & (i_paddr == `HSF_ADDR_CTRL);
   wire wr_mask  = wr_en & (i_paddr == `HSF_ADDR_ALERT);
   wire wr_fault = wr_en & (i_paddr == `HSF_ADDR_FAULT);
   wire halt     = ctrl_q[`HSF_CTRL_HALT];

   // Events
   wire brd_edge  = brd_prev_q ^ brd_n_s;
   wire brd_rise  = ~brd_prev_q & brd_n_s;
   wire brd_fall  = brd_prev_q & ~brd_n_s;
   wire on_rise   = ~on_prev_q & on_s;
   wire on_fall   = on_prev_q & ~on_s;
   wire ctl_fall  = ctl_prev_q & ~ctrl_q[`HSF_CTRL_ON];
   wire oc_evt    = oc_s & gate_q;
   wire short_evt = (state_q == ST_WAIT) & i_adc_done & (ch_q == 2'd0) & ~gate_q
                    & (i_adc_data >= `HSF_SHORT_CODE);
   wire gen_clr   = on_fall | ctl_fall | flt_met[3] | lock_s;
   wire [5:0] present = {2'b00, pb_pres_q, 1'b0, uv_pres_q, ov_pres_q};

   // Fault register next value, set wins over clear
   reg [5:0] f_set;
   reg [5:0] f_clr;
   always @* begin
      f_set = 6'h00;
      f_clr = 6'h00;
      f_set[`HSF_FLT_OV]    = flt_met[0];
      f_set[`HSF_FLT_UV]    = flt_met[1];
      f_set[`HSF_FLT_OC]    = oc_evt;
      f_set[`HSF_FLT_PB]    = flt_met[2];
      f_set[`HSF_FLT_BRD]   = brd_edge;
      f_set[`HSF_FLT_SHORT] = short_evt;
      if (wr_fault) begin
         f_set = f_set | i_pwdata[5:0];
         f_clr = ~i_pwdata[5:0];
      end
      if (gen_clr) begin
         f_clr = 6'h3f;
      end
      if (brd_fall) begin
         f_clr = f_clr | 6'h2f;
      end
      f_clr   = f_clr & ~present;
      fault_d = (fault_q & ~f_clr) | f_set;
   end

   // Switch hold terms
   wire ov_hold = ov_pres_q | (ctrl_q[`HSF_CTRL_OV_AR] ? ~qual_met[0] : fault_q[`HSF_FLT_OV]);
   wire uv_hold = uv_pres_q | (ctrl_q[`HSF_CTRL_UV_AR] ? ~qual_met[1] : fault_q[`HSF_FLT_UV]);
   wire oc_hold = (cool_q != {`HSF_COOL_W{1'b0}})
                  | (~ctrl_q[`HSF_CTRL_OC_AR] & fault_q[`HSF_FLT_OC]);
   wire gate_d  = brd_pres_q & ~brd_n_s & brd_qual_q & ctrl_q[`HSF_CTRL_ON]
                  & ~ov_hold & ~uv_hold & ~oc_hold & ~oc_evt & ~lock_s & ~flt_met[0] & ~flt_met[1];

   // Alert
   wire [5:0] masked   = fault_q & mask_q;
   wire       new_alrt = |(masked & ~masked_prev_q);
   wire       alrt_rel = alert_pend_q & ((i_ara_won & ~force_q) | i_dev_addressed);
   wire       pend_d   = new_alrt | (alert_pend_q & ~alrt_rel);

   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         fault_q       <= 6'h00;
         force_q       <= 1'b0;
         mask_q        <= 6'h00;
         ov_pres_q     <= 1'b0;
         uv_pres_q     <= 1'b0;
         pb_pres_q     <= 1'b0;
         brd_pres_q    <= 1'b0;
         brd_prev_q    <= 1'b1;
         brd_qual_q    <= 1'b0;
         on_prev_q     <= 1'b0;
         ctl_prev_q    <= 1'b0;
         gate_q        <= 1'b0;
         pgood_low_q   <= 1'b0;
         alert_pend_q  <= 1'b0;
         alert_out_q   <= 1'b0;
         masked_prev_q <= 6'h00;
         cool_q        <= {`HSF_COOL_W{1'b0}};
      end else begin
         fault_q       <= fault_d;
         ov_pres_q     <= flt_met[0];
         uv_pres_q     <= flt_met[1];
         if (flt_met[2]) begin
            pb_pres_q <= 1'b1;
         end else if (fb_s) begin
            pb_pres_q <= 1'b0;
         end
         pgood_low_q   <= ctrl_q[`HSF_CTRL_PG_MODE] & (flt_met[2] | (pb_pres_q & ~fb_s));
         brd_prev_q    <= brd_n_s;
         if (brd_rise) begin
            brd_pres_q <= 1'b0;
         end else if (brd_fall) begin
            brd_pres_q <= 1'b1;
         end
         brd_qual_q    <= qual_met[2];
         on_prev_q     <= on_s;
         ctl_prev_q    <= ctrl_q[`HSF_CTRL_ON];
         gate_q        <= gate_d;
         if (wr_fault) begin
            force_q <= i_pwdata[`HSF_FLT_FORCE];
         end
         if (wr_mask) begin
            mask_q <= i_pwdata[5:0];
         end
         alert_pend_q  <= pend_d;
         alert_out_q   <= force_q | pend_d;
         masked_prev_q <= masked;
         if (oc_evt) begin
            cool_q <= COOL_CYC[`HSF_COOL_W-1:0];
         end else if (cool_q != {`HSF_COOL_W{1'b0}}) begin
            cool_q <= cool_q - 1'b1;
         end
      end
   end

   // Control register with on-request tracking
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         ctrl_q <= `HSF_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= {1'b0, i_pwdata[6:5], 1'b0, i_pwdata[3:0]};
      end else if (qual_met[2] & ~brd_qual_q) begin
         ctrl_q[`HSF_CTRL_ON] <= on_s;
      end else if (brd_qual_q & (on_rise | on_fall)) begin
         ctrl_q[`HSF_CTRL_ON] <= on_s;
      end
   end

   // Converter sequencing
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state_q <= ST_IDLE;
         ch_q    <= 2'd0;
         start_q <= 1'b0;
         per_q   <= {`HSF_QUAL_W{1'b0}};
         res_q[0] <= 8'h00;
         res_q[1] <= 8'h00;
         res_q[2] <= 8'h00;
      end else begin
         start_q <= 1'b0;
         if (per_q == ADC_PER_CYC[`HSF_QUAL_W-1:0] - 1'b1) begin
            per_q <= {`HSF_QUAL_W{1'b0}};
         end else begin
            per_q <= per_q + 1'b1;
         end
         if (halt) begin
            state_q <= ST_IDLE;
            if (wr_en & (i_paddr == `HSF_ADDR_SENSE)) begin
               res_q[0] <= i_pwdata[7:0];
            end
            if (wr_en & (i_paddr == `HSF_ADDR_SOURCE)) begin
               res_q[1] <= i_pwdata[7:0];
            end
            if (wr_en & (i_paddr == `HSF_ADDR_AUX)) begin
               res_q[2] <= i_pwdata[7:0];
            end
         end else begin
            case (state_q)
               ST_IDLE: begin
                  if (per_q == {`HSF_QUAL_W{1'b0}}) begin
                     ch_q    <= 2'd0;
                     start_q <= 1'b1;
                     state_q <= ST_WAIT;
                  end
               end
               ST_WAIT: begin
                  if (i_adc_done) begin
                     res_q[ch_q] <= i_adc_data;
                     if (ch_q == 2'd2) begin
                        state_q <= ST_IDLE;
                     end else begin
                        ch_q    <= ch_q + 2'd1;
                        start_q <= 1'b1;
                     end
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Read mux
   always @* begin
      mapped = 1'b1;
      rd_val = 32'h0000_0000;
      case (i_paddr)
         `HSF_ADDR_CTRL:   rd_val[7:0] = ctrl_q;
         `HSF_ADDR_ALERT:  rd_val[5:0] = mask_q;
         `HSF_ADDR_STATUS: rd_val[4:0] = {brd_pres_q, pb_pres_q, 1'b0, uv_pres_q, ov_pres_q};
         `HSF_ADDR_FAULT:  rd_val[6:0] = {force_q, fault_q};
         `HSF_ADDR_SENSE:  rd_val[7:0] = res_q[0];
         `HSF_ADDR_SOURCE: rd_val[7:0] = res_q[1];
         `HSF_ADDR_AUX:    rd_val[7:0] = res_q[2];
         default:          mapped = 1'b0;
      endcase
   end

   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_ph & ~i_pwrite) begin
         prdata_q <= rd_val;
      end
   end

   assign o_prdata         = prdata_q;
   assign o_pready         = 1'b1;
   assign o_pslverr        = acc_ph & ~mapped;
   assign o_gate_drive     = gate_q;
   assign o_pgood_pull_low = pgood_low_q;
   assign o_alert_pull_low = alert_out_q;
   assign o_ara_respond    = alert_pend_q & ~force_q;
   assign o_adc_start      = start_q;
   assign o_adc_channel    = ch_q;
endmodule // hsf_fault_ctl

// >>> design/hsf_qual.v
// Qualification counter: condition must hold for LIMIT cycles
`timescale 1ns/1ps
module hsf_qual #(
   parameter             CNT_W = 6,
   parameter [CNT_W-1:0] LIMIT = 1
) (
   input  wire i_sys_clk,
   input  wire i_sys_rst,
   input  wire i_cond,
   output wire o_met
);
   reg [CNT_W-1:0] cnt_q;

   // Restarts whenever the condition drops
   always @(posedge i_sys_clk) begin
      if (i_sys_rst || !i_cond) begin
         cnt_q <= {CNT_W{1'b0}};
      end else if (cnt_q != LIMIT) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign o_met = i_cond && (cnt_q == LIMIT);
endmodule // hsf_qual

// >>> design/hsf_sync.v
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module hsf_sync #(
   parameter WIDTH = 1
) (
   input  wire             i_sys_clk,
   input  wire             i_sys_rst,
   input  wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule // hsf_sync
